/* src/btc_pkg.sv */
/*
 * shared constants and carrier types for the two-wire bus transceiver control block.
 * assumes a 250 MHz core clock and a 32-bit avalon-mm register slave with byte addresses.
 */
package btc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned TICK_NS        = 1000;
    localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned TERM_TIME_US   = 34;
    localparam int unsigned TERM_TICKS     = (TERM_TIME_US * 1000) / TICK_NS;
    localparam int unsigned WD_TIME_MS     = 21;
    localparam int unsigned WD_TICKS       = (WD_TIME_MS * 1000000) / TICK_NS;
    localparam int unsigned FIFO_WIDTH     = 16;
    localparam int unsigned FIFO_DEPTH     = 8;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_RXFIFO     = 4'h8;
    localparam int unsigned CTRL_WD_ALLOW  = 0;
    localparam int unsigned STAT_WD_TRIP   = 3;
    localparam int unsigned STAT_OVERFLOW  = 4;
    localparam logic        CTRL_WD_RESET  = 1'b1;

    typedef enum logic {
        BTC_TX_IDLE  = 1'b0,
        BTC_TX_DRIVE = 1'b1
    } btc_tx_state_t;

    typedef struct packed {
        logic highpass_on;
        logic polarity;
        logic fifo_nonempty;
        logic overflow;
        logic wd_tripped;
        logic rx_low;
        logic term_closed;
        logic driving;
    } btc_status_t;
endpackage

/* src/btc_top.sv */
/*
 * transceiver control logic: pulse transmit, dynamic termination, receive output,
 * watchdog, receive-pulse fifo and avalon-mm register slave.
 * assumes all pins are synchronous to i_clk and comparator results arrive as levels.
 */
// Notes on behaviour
// - a falling transmit edge starts driving the pair with the opposite polarity, a rising edge floats both lines.
// - when the driver drops to high impedance the termination switch from line a to the termination pin closes.
// - the switch opens after the nominal 34 us, when the receive output goes low, or when bus reset rises.
// - the transmitter works only while bus reset is low and the receiver is always on.
// - receive output pulls low past the leading threshold of either sign and floats past the trailing one.
// - the high-pass filter is on while its active-low enable is low and bypassed while high.
// - the watchdog runs while its active-low enable is low and the control register allow bit is set; the pad pulldown makes that the default.
// - an enabled watchdog floats both lines after transmit data stays low longer than 21 ms.
// - every transmit transition restarts the watchdog interval.
`timescale 1ns/10ps

module btc_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("btc_fifo: depth below 2 or zero width");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign o_in_ready  = (count != CW'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_ce & i_in_valid & o_in_ready;
    assign pop         = i_ce & o_out_valid & i_out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end
endmodule

module btc_top
    import btc_pkg::*;
#(
    parameter int unsigned P_TICK_CYCLES = TICK_CYCLES,
    parameter int unsigned P_TERM_TICKS  = TERM_TICKS,
    parameter int unsigned P_WD_TICKS    = WD_TICKS
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    input  wire logic        i_tx_data,
    input  wire logic        i_bus_reset,
    input  wire logic        i_lead_cross,
    input  wire logic        i_trail_below,
    input  wire logic        i_highpass_enable_n,
    input  wire logic        i_watchdog_enable_n,
    output logic             o_bus_line_a,
    output logic             o_bus_line_a_oe,
    output logic             o_bus_line_b,
    output logic             o_bus_line_b_oe,
    output logic             o_term_switch,
    output logic             o_rx_data,
    output logic             o_rx_data_oe,
    output logic             o_highpass_on,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);
    localparam int unsigned PW = (P_TICK_CYCLES > 1) ? $clog2(P_TICK_CYCLES) : 1;
    localparam int unsigned TW = $clog2(P_TERM_TICKS + 1);
    localparam int unsigned WW = $clog2(P_WD_TICKS + 1);

    if (P_TICK_CYCLES < 2 || P_TERM_TICKS < 1 || P_WD_TICKS < 1) begin : g_bad_counts
        $error("btc_top: time base and interval counts must be at least 2, 1 and 1");
    end

    // ------------------------------------------------------------
    // time base and transmit path
    // ------------------------------------------------------------
    btc_tx_state_t    tx_state;
    btc_tx_state_t    next_tx_state;
    logic [PW-1:0]    tick_cnt;
    logic [PW-1:0]    next_tick_cnt;
    logic             tick;
    logic             tx_prev;
    logic             polarity;
    logic             next_polarity;
    logic [WW-1:0]    wd_ticks;
    logic [WW-1:0]    next_wd_ticks;
    logic             wd_allow;
    logic             wd_on;
    logic             wd_expire;
    logic             tx_fall;
    logic             tx_rise;
    logic             drive_end;

    assign tick      = (tick_cnt == PW'(P_TICK_CYCLES - 1));
    assign tx_fall   = tx_prev & ~i_tx_data;
    assign tx_rise   = ~tx_prev & i_tx_data;
    assign wd_on     = ~i_watchdog_enable_n & wd_allow;
    // "more than" the interval: trips on the tick after the count has reached it
    assign wd_expire = wd_on & ~i_tx_data & tick & (wd_ticks == WW'(P_WD_TICKS));
    assign drive_end = (tx_state == BTC_TX_DRIVE) && (next_tx_state == BTC_TX_IDLE);

    always_comb begin
        next_tick_cnt = tick ? '0 : tick_cnt + PW'(1);
        next_tx_state = tx_state;
        next_polarity = polarity;
        next_wd_ticks = wd_ticks;
        unique case (tx_state)
            BTC_TX_IDLE: begin
                if (tx_fall && !i_bus_reset) begin
                    next_tx_state = BTC_TX_DRIVE;
                    next_polarity = ~polarity;
                end
            end
            BTC_TX_DRIVE: begin
                if (tx_rise || i_bus_reset || wd_expire) begin
                    next_tx_state = BTC_TX_IDLE;
                end
            end
        endcase
        if (i_tx_data || tx_fall) begin
            next_wd_ticks = '0;
        end else if (tick && wd_ticks != WW'(P_WD_TICKS)) begin
            next_wd_ticks = wd_ticks + WW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tick_cnt <= '0;
            tx_state <= BTC_TX_IDLE;
            tx_prev  <= 1'b1;
            polarity <= 1'b0;
            wd_ticks <= '0;
        end else if (i_ce) begin
            tick_cnt <= next_tick_cnt;
            tx_state <= next_tx_state;
            tx_prev  <= i_tx_data;
            polarity <= next_polarity;
            wd_ticks <= next_wd_ticks;
        end
    end

    assign o_bus_line_a    = polarity;
    assign o_bus_line_b    = ~polarity;
    assign o_bus_line_a_oe = (tx_state == BTC_TX_DRIVE);
    assign o_bus_line_b_oe = (tx_state == BTC_TX_DRIVE);

    // ------------------------------------------------------------
    // termination, receive output, filter select
    // ------------------------------------------------------------
    logic             term_on;
    logic             next_term_on;
    logic [TW-1:0]    term_ticks;
    logic [TW-1:0]    next_term_ticks;
    logic             rx_low;
    logic             next_rx_low;
    logic             highpass_on;
    logic [15:0]      rx_ticks;
    logic [15:0]      next_rx_ticks;

    always_comb begin
        next_term_on    = term_on;
        next_term_ticks = term_ticks;
        if (i_bus_reset || rx_low || (term_on && term_ticks == TW'(P_TERM_TICKS))) begin
            next_term_on = 1'b0;
        end else if (drive_end) begin
            next_term_on    = 1'b1;
            next_term_ticks = '0;
        end else if (next_tx_state == BTC_TX_DRIVE) begin
            next_term_on = 1'b0;
        end else if (term_on && tick) begin
            next_term_ticks = term_ticks + TW'(1);
        end
        // leading threshold wins: a pulse cannot be both rising and decaying
        if (i_lead_cross) begin
            next_rx_low = 1'b1;
        end else if (i_trail_below) begin
            next_rx_low = 1'b0;
        end else begin
            next_rx_low = rx_low;
        end
        if (!rx_low) begin
            next_rx_ticks = '0;
        end else if (tick && rx_ticks != 16'hffff) begin
            next_rx_ticks = rx_ticks + 16'h0001;
        end else begin
            next_rx_ticks = rx_ticks;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            term_on     <= 1'b0;
            term_ticks  <= '0;
            rx_low      <= 1'b0;
            rx_ticks    <= '0;
            highpass_on <= 1'b0;
        end else if (i_ce) begin
            term_on     <= next_term_on;
            term_ticks  <= next_term_ticks;
            rx_low      <= next_rx_low;
            rx_ticks    <= next_rx_ticks;
            highpass_on <= ~i_highpass_enable_n;
        end
    end

    assign o_term_switch = term_on;
    assign o_rx_data     = 1'b0;
    assign o_rx_data_oe  = rx_low;
    assign o_highpass_on = highpass_on;

    // ------------------------------------------------------------
    // receive-pulse fifo: low-period length in ticks per pulse
    // ------------------------------------------------------------
    logic             cap_valid;
    logic             next_cap_valid;
    logic [15:0]      cap_data;
    logic [15:0]      next_cap_data;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic [15:0]      fifo_out_data;
    logic             fifo_pop;
    logic             rx_done;
    logic             overflow_set;

    assign rx_done = rx_low & ~next_rx_low;

    // a pending word stalls capture while the fifo is full; a second pulse then is lost
    always_comb begin
        next_cap_valid = cap_valid & ~fifo_in_ready;
        next_cap_data  = cap_data;
        overflow_set   = 1'b0;
        if (rx_done) begin
            if (next_cap_valid) begin
                overflow_set = 1'b1;
            end else begin
                next_cap_valid = 1'b1;
                next_cap_data  = rx_ticks;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cap_valid <= 1'b0;
            cap_data  <= '0;
        end else if (i_ce) begin
            cap_valid <= next_cap_valid;
            cap_data  <= next_cap_data;
        end
    end

    btc_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_ce        (i_ce),
        .i_in_valid  (cap_valid),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (cap_data),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // avalon-mm slave: one wait state on every access
    // ------------------------------------------------------------
    logic             ack;
    logic             next_ack;
    logic [31:0]      readdata;
    logic [31:0]      next_readdata;
    logic             wd_trip;
    logic             next_wd_trip;
    logic             overflow;
    logic             next_overflow;
    logic             next_wd_allow;
    logic             wr_hit;
    btc_status_t      status;

    assign status = '{highpass_on: highpass_on, polarity: polarity,
                      fifo_nonempty: fifo_out_valid, overflow: overflow,
                      wd_tripped: wd_trip, rx_low: rx_low, term_closed: term_on,
                      driving: (tx_state == BTC_TX_DRIVE)};
    // a frozen clock enable must not let the master finish an access that never lands
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~(ack & i_ce);
    assign wr_hit   = i_avs_write & ack & i_avs_byteenable[0];
    assign fifo_pop = i_avs_read & ack & (i_avs_address == REG_RXFIFO);

    always_comb begin
        next_ack      = (i_avs_read | i_avs_write) & ~ack;
        next_readdata = readdata;
        next_wd_allow = wd_allow;
        if (i_avs_read && !ack) begin
            unique case (i_avs_address)
                REG_CTRL:   next_readdata = {31'h0, wd_allow};
                REG_STATUS: next_readdata = {24'h0, status};
                REG_RXFIFO: next_readdata = {16'h0, fifo_out_valid ? fifo_out_data : 16'h0};
                default:    next_readdata = 32'h0;
            endcase
        end
        if (wr_hit && i_avs_address == REG_CTRL) begin
            next_wd_allow = i_avs_writedata[CTRL_WD_ALLOW];
        end
        // hardware set wins over a write-one clear in the same cycle
        next_wd_trip  = (wd_trip & ~(wr_hit && i_avs_address == REG_STATUS
                        && i_avs_writedata[STAT_WD_TRIP])) | wd_expire;
        next_overflow = (overflow & ~(wr_hit && i_avs_address == REG_STATUS
                        && i_avs_writedata[STAT_OVERFLOW])) | overflow_set;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ack      <= 1'b0;
            readdata <= '0;
            wd_allow <= CTRL_WD_RESET;
            wd_trip  <= 1'b0;
            overflow <= 1'b0;
        end else if (i_ce) begin
            ack      <= next_ack;
            readdata <= next_readdata;
            wd_allow <= next_wd_allow;
            wd_trip  <= next_wd_trip;
            overflow <= next_overflow;
        end
    end

    assign o_avs_readdata = readdata;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    fall_drives_a: assert property (i_ce && tx_prev && !i_tx_data && !i_bus_reset
        && !o_bus_line_a_oe |=> o_bus_line_a_oe && o_bus_line_b_oe
        && o_bus_line_a != $past(o_bus_line_a))
        else $error("falling edge did not start an inverted pulse");
    rise_floats_a: assert property (i_ce && tx_rise |=> !o_bus_line_a_oe
        && !o_bus_line_b_oe)
        else $error("rising edge left the pair driven");
    term_close_a: assert property (i_ce && drive_end && !i_bus_reset && !rx_low
        |=> o_term_switch)
        else $error("switch did not close on release");
    term_open_a: assert property (i_ce && (i_bus_reset || rx_low) |=> !o_term_switch)
        else $error("switch stayed closed after reset or receive");
    term_bound_a: assert property (i_ce && o_term_switch
        && term_ticks == TW'(P_TERM_TICKS) |=> !o_term_switch)
        else $error("switch held past its interval");
    reset_stops_a: assert property (i_ce && i_bus_reset |=> !o_bus_line_a_oe)
        else $error("transmitter active under bus reset");
    rx_assert_a: assert property (i_ce && i_lead_cross |=> o_rx_data_oe && !o_rx_data)
        else $error("receive output not pulled low");
    rx_release_a: assert property (i_ce && i_trail_below && !i_lead_cross
        |=> !o_rx_data_oe)
        else $error("receive output not released");
    filter_sel_a: assert property (i_ce ##1 i_ce |-> o_highpass_on
        == !$past(i_highpass_enable_n))
        else $error("filter select wrong");
    wd_off_a: assert property (i_ce && i_watchdog_enable_n && o_bus_line_a_oe
        && !i_tx_data && !i_bus_reset |=> o_bus_line_a_oe)
        else $error("watchdog fired while disabled");
    wd_release_a: assert property (i_ce && wd_expire |=> !o_bus_line_a_oe
        && !o_bus_line_b_oe && status.wd_tripped)
        else $error("watchdog did not release the bus");
    wd_restart_a: assert property (i_ce && (tx_prev != i_tx_data) |=> wd_ticks == '0)
        else $error("transition did not restart watchdog");

    pulse_cycle_c: cover property (o_bus_line_a_oe ##1 !o_bus_line_a_oe && o_term_switch);
    term_timeout_c: cover property (o_term_switch && term_ticks == TW'(P_TERM_TICKS));
    wd_trip_c: cover property (wd_expire);
    fifo_full_c: cover property (!fifo_in_ready);
endmodule

/* sim/btc_bus_model.sv */
/*
 * far-side model of the bus pair: comparator levels seen while another node pulses.
 * assumes the bench calls its tasks between clock edges.
 */
`timescale 1ns/10ps
module btc_bus_model (
    input  wire logic i_clk,
    output logic      o_lead_cross,
    output logic      o_trail_below
);
    // ------------------------------------------------------------
    // remote pulse levels
    // ------------------------------------------------------------
    initial begin
        o_lead_cross  = 1'b0;
        o_trail_below = 1'b1;
    end
    // a real edge spends a cycle between the two thresholds, so both levels are low there
    task automatic lead_on();
        @(posedge i_clk);
        o_trail_below <= 1'b0;
        @(posedge i_clk);
        o_lead_cross <= 1'b1;
    endtask
    task automatic lead_off();
        @(posedge i_clk);
        o_lead_cross <= 1'b0;
        @(posedge i_clk);
        o_trail_below <= 1'b1;
    endtask
endmodule

/* sim/tb_bus_transceiver_control.sv */
/*
 * self-checking bench for the transceiver control block against a queue model.
 * assumes shortened counts: 4-cycle tick, 3-tick termination, 10-tick watchdog.
 */
`timescale 1ns/10ps
module tb_bus_transceiver_control;
    import btc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, tx = 1'b1, brst = 1'b0, hp_n = 1'b0, wd_n = 1'b0;
    logic        lead, trail, la, la_oe, lb, lb_oe, term, rxd, rx_oe, hp_on, waitreq;
    logic        rd_en = 1'b0, wr_en = 1'b0, exp_pol = 1'b0, exp_ovf = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rd, seed = 32'hed4a46af;
    int          error_cnt = 0, check_count = 0, exp_q[$], plen;

    always #2 clk = ~clk;

    btc_top #(.P_TICK_CYCLES(4), .P_TERM_TICKS(3), .P_WD_TICKS(10)) u_dut (
        .i_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_tx_data(tx), .i_bus_reset(brst),
        .i_lead_cross(lead), .i_trail_below(trail), .i_highpass_enable_n(hp_n),
        .i_watchdog_enable_n(wd_n), .o_bus_line_a(la), .o_bus_line_a_oe(la_oe),
        .o_bus_line_b(lb), .o_bus_line_b_oe(lb_oe), .o_term_switch(term), .o_rx_data(rxd),
        .o_rx_data_oe(rx_oe), .o_highpass_on(hp_on), .i_avs_address(addr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));
    btc_bus_model u_model (.i_clk(clk), .o_lead_cross(lead), .o_trail_below(trail));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // holds the request until waitrequest is sampled low; only the bench watchdog ends a hang
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        @(posedge clk);
        addr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= wd;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        r = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rx_pulse(input int len);
        u_model.lead_on();
        cyc(1);
        chk("rx_pull_low", 1, rx_oe & !rxd);
        cyc(1);
        chk("term_rx_open", 0, term);
        cyc(len);
        u_model.lead_off();
        cyc(1);
        chk("rx_release", 0, rx_oe);
        if (exp_q.size() < FIFO_DEPTH + 1) exp_q.push_back(len);
        else exp_ovf = 1'b1;
    endtask
    // mode 0: termination times out, 1: remote pulse opens it, 2: bus reset opens it
    task automatic tx_pulse(input int lo, input logic trip, input int mode);
        @(posedge clk);
        tx <= 1'b0;
        exp_pol = !exp_pol;
        cyc(1);
        chk("line_a_oe", 1, la_oe);
        chk("line_a", exp_pol, la);
        chk("line_b", !exp_pol, lb);
        cyc(lo);
        chk("drive_held", !trip, la_oe & lb_oe);
        @(posedge clk);
        tx <= 1'b1;
        cyc(1);
        chk("line_b_oe", 0, lb_oe);
        if (!trip) chk("term_closed", 1, term);
        if (mode == 1) rx_pulse(4);
        if (mode == 2) begin
            @(posedge clk);
            brst <= 1'b1;
            cyc(2);
            chk("term_reset_open", 0, term);
            @(posedge clk);
            tx <= 1'b0;
            cyc(2);
            chk("tx_disabled", 0, la_oe);
            @(posedge clk);
            tx <= 1'b1;
            brst <= 1'b0;
        end
        cyc(8);
        if (mode == 0 && !trip) chk("term_held", 1, term);
        cyc(12); // bus reset stays low past the interval
        chk("term_timeout", 0, term);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk);
        $display("unexpected run_time expected done seen hang");
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk("reset_oe", 0, la_oe | term);
        avs(0, REG_CTRL, 32'h0, rd);
        chk("ctrl_reset", 32'h1, rd);
        avs(0, 4'hc, 32'h0, rd);
        chk("unmapped_read", 32'h0, rd);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            tx_pulse(1 + seed[2:0], 1'b0, 0);
        end
        tx_pulse(3, 1'b0, 1);
        tx_pulse(3, 1'b0, 2);
        $display("test transmit done");
        tx_pulse(60, 1'b1, 0);
        avs(0, REG_STATUS, 32'h0, rd);
        chk("wd_trip", 1, rd[STAT_WD_TRIP]);
        avs(1, REG_STATUS, 32'h8, rd);
        avs(0, REG_STATUS, 32'h0, rd);
        chk("wd_clear", 0, rd[STAT_WD_TRIP]);
        tx_pulse(30, 1'b0, 0);
        tx_pulse(30, 1'b0, 0);
        @(posedge clk);
        wd_n <= 1'b1;
        tx_pulse(60, 1'b0, 0);
        @(posedge clk);
        wd_n <= 1'b0;
        avs(1, REG_CTRL, 32'h0, rd);
        avs(0, REG_CTRL, 32'h0, rd);
        chk("ctrl_write", 32'h0, rd);
        tx_pulse(60, 1'b0, 0);
        avs(1, REG_CTRL, 32'h1, rd);
        $display("test watchdog done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            seed = lfsr(seed);
            hp_n <= seed[0];
            cyc(1);
            chk("highpass_on", !hp_n, hp_on);
        end
        $display("test highpass done");
        for (int i = 0; i < 10; i++) rx_pulse(8);
        avs(0, REG_STATUS, 32'h0, rd);
        chk("overflow", exp_ovf, rd[STAT_OVERFLOW]);
        // receive low lasts len+3 counted edges; the free 4-cycle tick makes it one of two counts
        while (exp_q.size() > 0) begin
            avs(0, REG_RXFIFO, 32'h0, rd);
            plen = exp_q.pop_front();
            chk("fifo_word", 1, rd[15:0] >= (plen + 3) / 4 && rd[15:0] <= (plen + 6) / 4);
        end
        avs(0, REG_STATUS, 32'h0, rd);
        chk("fifo_nonempty", 0, rd[5]);
        avs(0, REG_RXFIFO, 32'h0, rd);
        chk("empty_read", 32'h0, rd);
        $display("test receive done");
        end_sim();
    end
endmodule
